// >>> aag_gate.sv
`include "aag_map.svh"

module aag_gate #(
   parameter int CNT_W = 8
) (
   input  wire logic                 clk,                // System clock, 20 MHz.
   input  wire logic                 nrst,               // Asynchronous reset, active low.
   input  wire logic                 external_arm_input, // Hardware arming line.
   input  wire logic                 frame_trig_in,      // Frame start trigger pulse.
   output logic                      frame_trig_out,     // Accepted frame start pulse.
   output logic                      armed,              // Frame starts are accepted.
   input  wire logic [31:0]          s_axi_awaddr,       // Write address.
   input  wire logic                 s_axi_awvalid,      // Write address valid.
   output logic                      s_axi_awready,      // Write address ready.
   input  wire logic [31:0]          s_axi_wdata,        // Write data.
   input  wire logic [3:0]           s_axi_wstrb,        // Write byte strobes.
   input  wire logic                 s_axi_wvalid,       // Write data valid.
   output logic                      s_axi_wready,       // Write data ready.
   output logic [1:0]                s_axi_bresp,        // Write response.
   output logic                      s_axi_bvalid,       // Write response valid.
   input  wire logic                 s_axi_bready,       // Write response ready.
   input  wire logic [31:0]          s_axi_araddr,       // Read address.
   input  wire logic                 s_axi_arvalid,      // Read address valid.
   output logic                      s_axi_arready,      // Read address ready.
   output aag_pkg::aag_word_t        s_axi_rdata,        // Read data.
   output logic [1:0]                s_axi_rresp,        // Read response.
   output logic                      s_axi_rvalid,       // Read data valid.
   input  wire logic                 s_axi_rready        // Read data ready.
);
   import aag_pkg::*;

   initial begin
      if (CNT_W != 8) begin
         $error("CNT_W must be 8 to hold counts up to 255.");
      end
   end

   // ==========================================================
   // Register bus slave
   logic                 aw_hold_q;
   logic [31:0]          aw_addr_q;
   logic                 w_hold_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 wr_go;
   logic                 wr_ctrl;
   logic                 wr_cmd;
   logic                 wr_count;
   logic                 wr_hit;
   logic [4:0]           ctrl_q;
   logic [CNT_W-1:0]     count_q;
   logic                 run_q;
   logic [CNT_W-1:0]     seen_q;
   aag_state_t           state_q;

   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign wr_ctrl       = wr_go && (aw_addr_q[7:2] == 6'(`AAG_CTRL_OFS >> 2));
   assign wr_cmd        = wr_go && (aw_addr_q[7:2] == 6'(`AAG_CMD_OFS >> 2));
   assign wr_count      = wr_go && (aw_addr_q[7:2] == 6'(`AAG_COUNT_OFS >> 2));
   assign wr_hit        = (aw_addr_q[31:8] == 24'h00_0000)
                          && (aw_addr_q[7:2] <= 6'(`AAG_STATUS_OFS >> 2));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         w_hold_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AAG_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `AAG_RESP_OKAY : `AAG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Status is read live, so the read takes one cycle after the address.
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `AAG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `AAG_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         if (s_axi_araddr[31:8] != 24'h00_0000) begin
            s_axi_rresp <= `AAG_RESP_SLVERR;
         end else begin
            unique case (s_axi_araddr[7:2])
               6'(`AAG_CTRL_OFS >> 2): s_axi_rdata <= {27'h0, ctrl_q};
               6'(`AAG_CMD_OFS >> 2): s_axi_rdata <= 32'h0000_0000;
               6'(`AAG_COUNT_OFS >> 2): s_axi_rdata <= {24'h0, count_q};
               6'(`AAG_STATUS_OFS >> 2): begin
                  s_axi_rdata <= {16'h0, seen_q, 6'h0,
                                  armed, run_q};
               end
               default: s_axi_rresp <= `AAG_RESP_SLVERR;
            endcase
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `AAG_CTRL_RST;
      end else if (wr_ctrl && w_strb_q[0]) begin
         ctrl_q <= w_data_q[4:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= `AAG_COUNT_RST;
      end else if (wr_count && w_strb_q[0]) begin
         count_q <= w_data_q[CNT_W-1:0];
      end
   end

   logic gate_en;
   logic src_hw;
   logic pol_fall;
   logic sel_arm;
   logic cmd_start;
   logic cmd_stop;
   logic cmd_swtrg;

   assign gate_en   = ctrl_q[`AAG_CTRL_EN_BIT];
   assign src_hw    = ctrl_q[`AAG_CTRL_SRC_BIT];
   assign pol_fall  = ctrl_q[`AAG_CTRL_POL_BIT];
   assign sel_arm   = ctrl_q[`AAG_CTRL_SEL_BIT];
   assign cmd_start = wr_cmd && w_strb_q[0] && w_data_q[`AAG_CMD_START_BIT];
   assign cmd_stop  = wr_cmd && w_strb_q[0] && w_data_q[`AAG_CMD_STOP_BIT];
   assign cmd_swtrg = wr_cmd && w_strb_q[0] && w_data_q[`AAG_CMD_SWTRG_BIT];

   // ==========================================================
   // External arming input
   logic [2:0] ext_sync_q;
   logic       hw_edge;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], external_arm_input};
      end
   end

   // Edge taken between the second and third stages only.
   assign hw_edge = pol_fall ? (ext_sync_q[2] && !ext_sync_q[1])
                             : (!ext_sync_q[2] && ext_sync_q[1]);

   logic arm_pulse;
   // A software trigger aimed at another target is not an arming event.
   assign arm_pulse = src_hw ? hw_edge
                             : (cmd_swtrg && sel_arm);

   // ==========================================================
   // Gate state machine
   logic frame_ok;
   assign frame_ok = (state_q == AAG_WAIT_FRAME);
   // Disabled gating passes every frame start while running.
   assign armed = run_q && (!gate_en || frame_ok);
   assign frame_trig_out = frame_trig_in && armed;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
      end else if (cmd_stop) begin
         run_q <= 1'b0;
      end else if (cmd_start) begin
         run_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= AAG_IDLE;
         seen_q  <= '0;
      end else if (cmd_stop || !gate_en) begin
         state_q <= AAG_IDLE;
         seen_q  <= '0;
      end else begin
         unique case (state_q)
            AAG_IDLE: begin
               if (cmd_start || run_q) begin
                  state_q <= AAG_WAIT_ARM;
               end
            end
            AAG_WAIT_ARM: begin
               seen_q <= '0;
               if (arm_pulse) begin
                  state_q <= AAG_WAIT_FRAME;
               end
            end
            AAG_WAIT_FRAME: begin
               if (frame_trig_in) begin
                  if (seen_q + 8'h01 >= count_q) begin
                     state_q <= AAG_WAIT_ARM;
                     seen_q  <= '0;
                  end else begin
                     seen_q <= seen_q + 8'h01;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   a_drop_unarmed: assert property (@(posedge clk) disable iff (!nrst)
      (gate_en && state_q == AAG_WAIT_ARM) |-> !frame_trig_out)
      else $error("Frame start passed while waiting for arm.");
   a_arm_moves: assert property (@(posedge clk) disable iff (!nrst)
      (gate_en && !cmd_stop && state_q == AAG_WAIT_ARM && arm_pulse)
      |=> state_q == AAG_WAIT_FRAME)
      else $error("Arming pulse did not arm.");
   a_disarm_count: assert property (@(posedge clk) disable iff (!nrst)
      (gate_en && !cmd_stop && frame_ok && frame_trig_in && seen_q + 8'h01 >= count_q)
      |=> state_q == AAG_WAIT_ARM)
      else $error("Gate did not disarm at frame count.");
   a_sw_arm: assert property (@(posedge clk) disable iff (!nrst)
      (!src_hw && cmd_swtrg && !sel_arm) |-> !arm_pulse)
      else $error("Software trigger armed with wrong target.");
   a_hw_rise: assert property (@(posedge clk) disable iff (!nrst)
      (src_hw && !pol_fall && $rose(ext_sync_q[2])) |-> $past(arm_pulse))
      else $error("Rising edge missed.");
   a_hw_only: assert property (@(posedge clk) disable iff (!nrst)
      (src_hw && arm_pulse) |-> (ext_sync_q[2] != ext_sync_q[1]))
      else $error("Arm pulse without line edge.");
   a_no_gate: assert property (@(posedge clk) disable iff (!nrst)
      (!gate_en && run_q && frame_trig_in) |-> frame_trig_out)
      else $error("Ungated frame start dropped.");
   a_wait_after_start: assert property (@(posedge clk) disable iff (!nrst)
      (gate_en && state_q == AAG_IDLE && cmd_start && !cmd_stop)
      |=> (state_q == AAG_WAIT_ARM && !armed))
      else $error("Start did not enter arm wait.");
   a_one_pulse: assert property (@(posedge clk) disable iff (!nrst)
      (src_hw && arm_pulse) |=> !arm_pulse)
      else $error("Edge pulse longer than one cycle.");
endmodule

// >>> aag_map.svh
`ifndef AAG_MAP_SVH
`define AAG_MAP_SVH
// Register byte offsets.
`define AAG_CTRL_OFS      32'h0000_0000
`define AAG_CMD_OFS       32'h0000_0004
`define AAG_COUNT_OFS     32'h0000_0008
`define AAG_STATUS_OFS    32'h0000_000c
// Control register fields.
`define AAG_CTRL_EN_BIT   0
`define AAG_CTRL_SRC_BIT  1
`define AAG_CTRL_POL_BIT  2
`define AAG_CTRL_SEL_BIT  3
`define AAG_CTRL_CONT_BIT 4
`define AAG_CTRL_RST      5'h10
// Command register fields, write one to act.
`define AAG_CMD_START_BIT 0
`define AAG_CMD_STOP_BIT  1
`define AAG_CMD_SWTRG_BIT 2
// Frame count register.
`define AAG_COUNT_RST     8'h01
// Status register fields.
`define AAG_ST_RUN_BIT    0
`define AAG_ST_ARMED_BIT  1
`define AAG_ST_CNT_LSB    8
// Bus responses.
`define AAG_RESP_OKAY     2'h0
`define AAG_RESP_SLVERR   2'h2
`endif

// >>> aag_pkg.sv
package aag_pkg;
   typedef enum logic [1:0] {
      AAG_IDLE,
      AAG_WAIT_ARM,
      AAG_WAIT_FRAME
   } aag_state_t;
   typedef logic [31:0] aag_word_t;
endpackage

// >>> aag_trig_src.sv
// ==========================================================
// External trigger source: arming line and frame pulses.
module aag_trig_src (
   input  wire logic clk,                // System clock.
   output logic      external_arm_input, // Arming line, held between edges.
   output logic      frame_trig_in       // One-cycle frame start pulse.
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      external_arm_input = 1'b0;
      frame_trig_in      = 1'b0;
   end
   // The line is a level; only its edges mean anything to the gate.
   task automatic line(input logic v);
      @(posedge clk);
      external_arm_input <= v;
   endtask
   task automatic frame();
      @(posedge clk);
      frame_trig_in <= 1'b1;
      @(posedge clk);
      frame_trig_in <= 1'b0;
   endtask
endmodule

// >>> aag_gate_test.sv
`include "aag_map.svh"
module aag_gate_test;
   timeunit 1ns;
   timeprecision 1ns;
   import aag_pkg::*;
   logic clk, nrst, ext, ftin, ftout, armed;
   logic [31:0] awaddr, wdata, araddr;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   aag_word_t rdata;
   int failures, total_checks, outs, seen, n;
   aag_gate u_dut (.clk(clk), .nrst(nrst), .external_arm_input(ext), .frame_trig_in(ftin),
      .frame_trig_out(ftout), .armed(armed), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   aag_trig_src u_src (.clk(clk), .external_arm_input(ext), .frame_trig_in(ftin));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Accepted frame pulses are counted where they are settled, before the edge.
   always @(posedge clk) if (ftout === 1'b1) outs++;
   // ==========================================================
   // Checking and closing
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Frames that pass in one arm: never more than the programmed count.
   function automatic int accepted(input int sent, input int limit);
      return (sent < limit) ? sent : limit;
   endfunction
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask
   // ==========================================================
   // Register bus master
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      check("bresp", `AAG_RESP_OKAY, bresp);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      check("rresp", er, rresp);
      if (er == `AAG_RESP_OKAY) check("rdata", exp, rdata);
      rready <= 1'b0;
   endtask
   task automatic frames(input int k);
      repeat (k) u_src.frame();
      settle(1);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
      nrst = 1'b0;
      void'($urandom(32'h82dd));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(`AAG_CTRL_OFS, 32'h0000_0010, `AAG_RESP_OKAY);
      rd(`AAG_COUNT_OFS, 32'h0000_0001, `AAG_RESP_OKAY);
      rd(32'h0000_0010, 32'h0, `AAG_RESP_SLVERR);
      for (int i = 0; i < 2; i++) begin
         n = (i == 0) ? 255 : 1 + $urandom % 255;
         wr(`AAG_COUNT_OFS, n);
         wr(`AAG_CTRL_OFS, 32'h0000_0011);
         wr(`AAG_CMD_OFS, 32'h0000_0001);
         wr(`AAG_CMD_OFS, 32'h0000_0004);
         settle(2);
         check("armed sw untargeted", 1'b0, armed);
         seen = outs;
         frames(2);
         check("armed waiting", 1'b0, armed);
         check("frames dropped", seen, outs);
         wr(`AAG_CTRL_OFS, 32'h0000_0019);
         wr(`AAG_CMD_OFS, 32'h0000_0004);
         settle(2);
         check("armed sw", 1'b1, armed);
         rd(`AAG_STATUS_OFS, 32'h0000_0003, `AAG_RESP_OKAY);
         seen = outs;
         frames(1);
         rd(`AAG_STATUS_OFS, (n > 1) ? 32'h0000_0103 : 32'h0000_0001, `AAG_RESP_OKAY);
         frames(n + 1);
         check("frames passed", seen + accepted(n + 2, n), outs);
         check("armed after count", 1'b0, armed);
         rd(`AAG_STATUS_OFS, 32'h0000_0001, `AAG_RESP_OKAY);
      end
      for (int pol = 0; pol < 2; pol++) begin
         u_src.line(pol[0]);
         wr(`AAG_CMD_OFS, 32'h0000_0002);
         wr(`AAG_CTRL_OFS, 32'h0000_0013 | (pol << 2));
         wr(`AAG_CMD_OFS, 32'h0000_0001);
         wr(`AAG_CMD_OFS, 32'h0000_0004);
         settle(3);
         check("armed hw sw cmd", 1'b0, armed);
         u_src.line(pol[0]);
         u_src.line(!pol[0]);
         settle(6);
         check("armed active edge", 1'b1, armed);
         seen = outs;
         frames(n);
         settle(6);
         check("hw frames", seen + n, outs);
         check("armed held level", 1'b0, armed);
         u_src.line(pol[0]);
         settle(6);
         check("armed wrong edge", 1'b0, armed);
         u_src.line(!pol[0]);
         settle(6);
         check("armed re-arm", 1'b1, armed);
      end
      wr(`AAG_CMD_OFS, 32'h0000_0002);
      wr(`AAG_CTRL_OFS, 32'h0000_0010);
      wr(`AAG_CMD_OFS, 32'h0000_0001);
      settle(2);
      check("armed gate off", 1'b1, armed);
      seen = outs;
      frames(3);
      check("frames gate off", seen + 3, outs);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule
